/* File: core/nps_core.sv */
// word store with nibble pack, nibble unpack and byte swap operations
`timescale 1ns/100ps
`default_nettype none
`include "nps_regs.svh"

// Contract
// (RQ1) pack low nibbles into bits 4i..4i+3
// (RQ2) pack clears unused upper bits of destination
// (RQ3) pack count zero leaves destination unchanged
// (RQ4) unpack splits word into 4-bit groups
// (RQ5) nibble i goes to destination word i
// (RQ6) unpack zeroes upper twelve bits of each
// (RQ7) unpack count zero modifies nothing
// (RQ8) count above four raises error code
// (RQ9) out-of-range words raise same error code
// (RQ10) single swap exchanges the two bytes
// (RQ11) double swap exchanges bytes within each word
// (RQ12) continuous swap repeats every operation cycle
module nps_core (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // operation request
  input  wire logic                  scan_tick,
  input  wire logic                  cmd_en,
  input  wire logic                  pulse_mode,
  input  wire nps_pkg::nps_op_e      op_sel,
  input  wire logic [15:0]           src_addr,
  input  wire logic [15:0]           dst_addr,
  input  wire logic [15:0]           count,
  // word store access
  input  wire logic                  host_wr,
  input  wire logic [`NPS_AW-1:0]    host_addr,
  input  wire logic [15:0]           host_wdata,
  output logic      [15:0]           host_rdata,
  // error reporting
  input  wire logic                  err_clr,
  output logic                       operation_error_flag,
  output logic      [15:0]           operation_error_code,
  output logic                       op_done
);

  logic [15:0]        mem [`NPS_DEPTH];
  logic               en_prev_reg;
  logic               exec_go;
  logic [2:0]         n3;
  logic               cnt_bad;
  logic               range_bad;
  logic               is_nib;
  logic               bad;
  logic               go_ok;
  logic [16:0]        src_end;
  logic [16:0]        dst_end;
  logic [16:0]        src_x;
  logic [16:0]        dst_x;
  logic [`NPS_AW-1:0] rd_idx [`NPS_SLOTS];
  logic [`NPS_AW-1:0] wr_idx [`NPS_SLOTS];
  logic [63:0]        src_bus;
  logic [15:0]        pack_word;
  logic [63:0]        unpack_bus;
  logic [15:0]        swap_w0;
  logic [15:0]        swap_w1;
  logic [15:0]        dst_word0;

  // trigger: continuous forms run every tick, pulse forms only on the enable edge
  assign exec_go = scan_tick & cmd_en & (~pulse_mode | ~en_prev_reg); // [RQ12]

  // enable level seen at the previous operation cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_prev_reg <= 1'b0;
    end else if (scan_tick) begin
      en_prev_reg <= cmd_en;
    end
  end

  // operand checks, widened to 17 bits so the end address cannot wrap
  assign n3      = count[2:0];
  assign cnt_bad = count > `NPS_CNT_MAX; // [RQ8] negative counts look huge here
  assign src_x   = {1'b0, src_addr};
  assign dst_x   = {1'b0, dst_addr};
  assign src_end = src_x + {14'h0000, n3};
  assign dst_end = dst_x + {14'h0000, n3};
  assign is_nib  = (op_sel == nps_pkg::NPS_OP_PACK) | (op_sel == nps_pkg::NPS_OP_UNPACK);

  // device range of every word the operation touches
  always_comb begin
    range_bad = 1'b0;
    case (op_sel)
      nps_pkg::NPS_OP_PACK:   range_bad = (src_end > `NPS_DEPTH_X) | (dst_x >= `NPS_DEPTH_X);
      nps_pkg::NPS_OP_UNPACK: range_bad = (src_x >= `NPS_DEPTH_X) | (dst_end > `NPS_DEPTH_X);
      nps_pkg::NPS_OP_SWAP:   range_bad = src_x >= `NPS_DEPTH_X;
      nps_pkg::NPS_OP_SWAP_D: range_bad = (src_x + 17'h00002) > `NPS_DEPTH_X;
      default:                range_bad = 1'b1;
    endcase
  end

  // a zero count skips the range test of pack and unpack since nothing is touched
  assign bad   = is_nib ? (cnt_bad | ((n3 != 3'h0) & range_bad)) : range_bad; // [RQ8] [RQ9]
  assign go_ok = exec_go & ~bad;

  // word addresses of the four slots, wrap is harmless since range was checked
  for (genvar i = 0; i < `NPS_SLOTS; i++) begin : g_idx
    assign rd_idx[i] = src_addr[`NPS_AW-1:0] + `NPS_AW'(i);
    assign wr_idx[i] = dst_addr[`NPS_AW-1:0] + `NPS_AW'(i);
    assign src_bus[16*i +: 16] = mem[rd_idx[i]];
  end
  assign dst_word0 = mem[wr_idx[0]];

  nps_nibble_unit u_unit (
    .src_bus    (src_bus),
    .cnt        (n3),
    .pack_word  (pack_word),
    .unpack_bus (unpack_bus),
    .swap_w0    (swap_w0),
    .swap_w1    (swap_w1)
  );

  // word store: an operation owns the store for its cycle, a host write in that cycle is dropped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int k = 0; k < `NPS_DEPTH; k++) begin
        mem[k] <= `NPS_RST_WORD;
      end
    end else if (exec_go) begin
      if (go_ok) begin
        case (op_sel)
          nps_pkg::NPS_OP_PACK: begin
            if (n3 != 3'h0) begin
              mem[wr_idx[0]] <= pack_word; // [RQ1] [RQ2] [RQ3]
            end
          end
          nps_pkg::NPS_OP_UNPACK: begin
            for (int k = 0; k < `NPS_SLOTS; k++) begin
              if (3'(k) < n3) begin
                mem[wr_idx[k]] <= unpack_bus[16*k +: 16]; // [RQ4] [RQ6] [RQ7]
              end
            end
          end
          nps_pkg::NPS_OP_SWAP: begin
            mem[rd_idx[0]] <= swap_w0; // [RQ10] [RQ12]
          end
          nps_pkg::NPS_OP_SWAP_D: begin
            mem[rd_idx[0]] <= swap_w0; // [RQ11]
            mem[rd_idx[1]] <= swap_w1; // [RQ11]
          end
          default: begin
          end
        endcase
      end
    end else if (host_wr) begin
      mem[host_addr] <= host_wdata;
    end
  end

  // registered read port
  always_ff @(posedge core_clk) begin
    if (rst) begin
      host_rdata <= `NPS_RST_WORD;
    end else begin
      host_rdata <= mem[host_addr];
    end
  end

  // sticky error flag, a new error in the clear cycle still sets it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      operation_error_flag <= 1'b0;
    end else begin
      operation_error_flag <= (exec_go & bad) | (operation_error_flag & ~err_clr); // [RQ8] [RQ9]
    end
  end

  // error code holds the last error until the next one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      operation_error_code <= `NPS_RST_CODE;
    end else if (exec_go & bad) begin
      operation_error_code <= `NPS_ERR_RANGE; // [RQ8] [RQ9]
    end
  end

  // one pulse per evaluated operation, including skipped and failed ones
  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_done <= 1'b0;
    end else begin
      op_done <= exec_go;
    end
  end

  // checks on the datapath, all on core_clk
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_pack(logic [2:0] n);
    go_ok && op_sel == nps_pkg::NPS_OP_PACK && n3 == n;
  endsequence

  sequence s_unpack(logic [2:0] n);
    go_ok && op_sel == nps_pkg::NPS_OP_UNPACK && n3 == n;
  endsequence

  property p_pack_three;
    s_pack(3'h3) |=> mem[$past(wr_idx[0])] == ($past(pack_word) & 16'h0fff) &&
      mem[$past(wr_idx[0])][11:8] == $past(src_bus[35:32]);
  endproperty
  a_pack_three: assert property (p_pack_three) else $error("pack of three wrong"); // [RQ1]

  property p_pack_clear;
    s_pack(3'h1) |=> mem[$past(wr_idx[0])] == {12'h000, $past(src_bus[3:0])};
  endproperty
  a_pack_clear: assert property (p_pack_clear) else $error("pack upper bits not clear"); // [RQ2]

  property p_pack_zero;
    s_pack(3'h0) |=> mem[$past(wr_idx[0])] == $past(dst_word0) && op_done;
  endproperty
  a_pack_zero: assert property (p_pack_zero) else $error("pack of zero changed word"); // [RQ3]

  property p_unpack_four;
    s_unpack(3'h4) |=> mem[$past(wr_idx[1])] == (($past(src_bus[15:0]) >> 4) & 16'h000f) &&
      mem[$past(wr_idx[3])] == {12'h000, $past(src_bus[15:12])};
  endproperty
  a_unpack_four: assert property (p_unpack_four) else $error("unpack slot wrong"); // [RQ5]

  property p_unpack_upper;
    s_unpack(3'h2) |=> mem[$past(wr_idx[0])][15:4] == 12'h000 &&
      mem[$past(wr_idx[1])][15:4] == 12'h000;
  endproperty
  a_unpack_upper: assert property (p_unpack_upper) else $error("unpack upper bits set"); // [RQ6]

  property p_unpack_zero;
    s_unpack(3'h0) |=> mem[$past(wr_idx[0])] == $past(dst_word0);
  endproperty
  a_unpack_zero: assert property (p_unpack_zero) else $error("unpack of zero wrote"); // [RQ7]

  property p_cnt_err;
    exec_go && is_nib && cnt_bad |=>
      (operation_error_flag && operation_error_code == `NPS_ERR_RANGE) ##1
      operation_error_code == `NPS_ERR_RANGE;
  endproperty
  a_cnt_err: assert property (p_cnt_err) else $error("bad count not reported"); // [RQ8]

  property p_range_err;
    exec_go && op_sel == nps_pkg::NPS_OP_SWAP && src_x >= `NPS_DEPTH_X |=>
      operation_error_flag && operation_error_code == `NPS_ERR_RANGE;
  endproperty
  a_range_err: assert property (p_range_err) else $error("range error not reported"); // [RQ9]

  property p_swap;
    go_ok && op_sel == nps_pkg::NPS_OP_SWAP |=>
      mem[$past(rd_idx[0])] == {$past(src_bus[7:0]), $past(src_bus[15:8])};
  endproperty
  a_swap: assert property (p_swap) else $error("byte swap wrong"); // [RQ10]

  property p_swap_d;
    go_ok && op_sel == nps_pkg::NPS_OP_SWAP_D |=>
      mem[$past(rd_idx[1])] == {$past(src_bus[23:16]), $past(src_bus[31:24])} &&
      mem[$past(rd_idx[0])] == {$past(src_bus[7:0]), $past(src_bus[15:8])};
  endproperty
  a_swap_d: assert property (p_swap_d) else $error("double swap wrong"); // [RQ11]

  property p_cont;
    scan_tick && cmd_en && !pulse_mode |=> op_done;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous form skipped a cycle"); // [RQ12]

  property p_pulse_once;
    scan_tick && cmd_en && pulse_mode && en_prev_reg |=> !op_done;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("pulse form repeated"); // [RQ12]

  property p_set_wins;
    exec_go && bad && err_clr |=> operation_error_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("error lost in clear cycle"); // [RQ8]

  // a refused operation must leave the first destination word and the first source word alone
  property p_no_write;
    exec_go && bad |=> mem[$past(wr_idx[0])] == $past(dst_word0) &&
      mem[$past(rd_idx[0])] == $past(src_bus[15:0]);
  endproperty
  a_no_write: assert property (p_no_write) else $error("refused operation wrote"); // [RQ9]

  // error state only moves on an error or a clear
  property p_code_hold;
    !(exec_go && bad) |=> $stable(operation_error_code);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("error code moved"); // [RQ8]

  property p_clear;
    err_clr && !(exec_go && bad) |=> !operation_error_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("error flag not cleared"); // [RQ8]

  // completion pulse only follows an evaluated operation
  property p_idle_done;
    !exec_go |=> !op_done;
  endproperty
  a_idle_done: assert property (p_idle_done) else $error("completion without operation"); // [RQ12]

  property p_pulse_first;
    scan_tick && cmd_en && pulse_mode && !en_prev_reg |=> op_done;
  endproperty
  a_pulse_first: assert property (p_pulse_first) else $error("pulse form missed its edge"); // [RQ12]

endmodule
`default_nettype wire

/* File: core/nps_nibble_unit.sv */
// combinational nibble pack, nibble unpack and byte swap results
`timescale 1ns/100ps
`default_nettype none
`include "nps_regs.svh"

module nps_nibble_unit (
  // operands
  input  wire logic [63:0] src_bus,
  input  wire logic [2:0]  cnt,
  // results
  output logic      [15:0] pack_word,
  output logic      [63:0] unpack_bus,
  output logic      [15:0] swap_w0,
  output logic      [15:0] swap_w1
);

  // one slot per nibble position of the packed word
  for (genvar i = 0; i < `NPS_SLOTS; i++) begin : g_slot
    // source i low nibble lands at bits 4i..4i+3, unused slots read zero
    assign pack_word[4*i +: 4] = (3'(i) < cnt) ? src_bus[16*i +: 4] : 4'h0; // [RQ1] [RQ2]
    // nibble i of the first source goes to the low nibble of word i
    assign unpack_bus[16*i +: 16] = {12'h000, src_bus[4*i +: 4]}; // [RQ4] [RQ5] [RQ6]
  end

  // bytes swap inside each word, words never change places
  assign swap_w0 = {src_bus[7:0], src_bus[15:8]}; // [RQ10] [RQ11]
  assign swap_w1 = {src_bus[23:16], src_bus[31:24]}; // [RQ11]

endmodule
`default_nettype wire

/* File: core/nps_pkg.sv */
// types shared by the nibble pack, unpack and byte swap datapath
package nps_pkg;

  // operation selected for the current operation cycle
  typedef enum logic [1:0] {
    NPS_OP_PACK   = 2'b00,
    NPS_OP_UNPACK = 2'b01,
    NPS_OP_SWAP   = 2'b10,
    NPS_OP_SWAP_D = 2'b11
  } nps_op_e;

endpackage

/* File: core/nps_regs.svh */
// constants of the nibble pack, unpack and byte swap datapath
`ifndef NPS_REGS_SVH
`define NPS_REGS_SVH

// word store geometry
`define NPS_DEPTH      64
`define NPS_AW         6
`define NPS_DEPTH_X    17'h00040

// operand count limits and nibble slots
`define NPS_CNT_MAX    16'h0004
`define NPS_SLOTS      4
`define NPS_NIB        4

// error code stored on a bad count or a bad device range (decimal 6706)
`define NPS_ERR_RANGE  16'h1a32

// reset values
`define NPS_RST_WORD   16'h0000
`define NPS_RST_CODE   16'h0000

`endif

/* File: tb/nps_tb.sv */
// self-checking bench of the nibble pack, unpack and byte swap datapath
`timescale 1ns/100ps
`default_nettype none
`include "nps_regs.svh"

module testbench;
  // stimulus, all idle at time zero
  logic             core_clk   = 1'b0;
  logic             rst        = 1'b1;
  logic             scan_tick  = 1'b0;
  logic             cmd_en     = 1'b0;
  logic             pulse_mode = 1'b0;
  nps_pkg::nps_op_e op_sel     = nps_pkg::NPS_OP_PACK;
  logic [15:0]      src_addr   = 16'h0000;
  logic [15:0]      dst_addr   = 16'h0000;
  logic [15:0]      count      = 16'h0000;
  logic             host_wr    = 1'b0;
  logic [5:0]       host_addr  = 6'h00;
  logic [15:0]      host_wdata = 16'h0000;
  logic             err_clr    = 1'b0;
  // observed results
  logic [15:0]      host_rdata;
  logic             operation_error_flag;
  logic [15:0]      operation_error_code;
  logic             op_done;
  // reference store, error state and bookkeeping
  logic [15:0]      mdl [64];
  logic             ef = 1'b0;
  logic [15:0]      ec = 16'h0000;
  logic [31:0]      rs = 32'h0000fa13;
  logic [31:0]      r;
  int               errors = 0;
  int               samples_checked = 0;

  nps_core dut (.core_clk, .rst, .scan_tick, .cmd_en, .pulse_mode, .op_sel, .src_addr,
    .dst_addr, .count, .host_wr, .host_addr, .host_wdata, .host_rdata, .err_clr,
    .operation_error_flag, .operation_error_code, .op_done);

  // 250 MHz clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end

  // repeatable pseudo-random source
  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t word got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t flag got %b expected %b", $time, g, e);
    end
  endtask

  // expected effect of one evaluated operation; source word captured first for overlap
  task automatic mdl_op(input nps_pkg::nps_op_e o, input int s, input int d, input int n);
    logic [15:0] w;
    logic        bad;
    w = mdl[s[5:0]];
    bad = 1'b0;
    case (o)
      nps_pkg::NPS_OP_PACK: begin
        bad = n > 4 || (n > 0 && (s + n > 64 || d >= 64));
        if (!bad && n > 0) begin
          w = 16'h0000;
          for (int i = 0; i < n; i++) w[4*i+:4] = mdl[s+i][3:0];
          mdl[d] = w;
        end
      end
      nps_pkg::NPS_OP_UNPACK: begin
        bad = n > 4 || (n > 0 && (s >= 64 || d + n > 64));
        if (!bad) for (int i = 0; i < n; i++) mdl[d+i] = {12'h000, w[4*i+:4]};
      end
      nps_pkg::NPS_OP_SWAP: begin
        bad = s >= 64;
        if (!bad) mdl[s] = {w[7:0], w[15:8]};
      end
      default: begin
        bad = s + 2 > 64;
        if (!bad) begin
          mdl[s] = {w[7:0], w[15:8]};
          mdl[s+1] = {mdl[s+1][7:0], mdl[s+1][15:8]};
        end
      end
    endcase
    if (bad) begin
      ef = 1'b1;
      ec = `NPS_ERR_RANGE;
    end
  endtask

  // one operation-cycle tick; ex says whether it should be evaluated
  task automatic tk(input logic en, input logic p, input nps_pkg::nps_op_e o,
                    input logic [15:0] s, input logic [15:0] d, input logic [15:0] n,
                    input logic ex);
    @(posedge core_clk);
    scan_tick <= 1'b1;
    cmd_en <= en;
    pulse_mode <= p;
    op_sel <= o;
    src_addr <= s;
    dst_addr <= d;
    count <= n;
    @(posedge core_clk);
    scan_tick <= 1'b0;
    cmd_en <= 1'b0;
    #1;
    chk1(op_done, ex);
    if (ex) mdl_op(o, s, d, n);
    chk1(operation_error_flag, ef);
    chk16(operation_error_code, ec);
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge core_clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= v;
    mdl[a] = v;
    @(posedge core_clk);
    host_wr <= 1'b0;
  endtask

  // whole store compared, so stray writes show up as well
  task automatic chk_all(input string nm);
    for (int a = 0; a < 64; a++) begin
      @(posedge core_clk);
      host_addr <= a[5:0];
      repeat (2) @(posedge core_clk);
      #1;
      chk16(host_rdata, mdl[a]);
    end
    $display("test %s done", nm);
  endtask

  task automatic clr();
    @(posedge core_clk);
    err_clr <= 1'b1;
    @(posedge core_clk);
    err_clr <= 1'b0;
    ef = 1'b0;
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog sized well above the expected run of about 1400 cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    finish_test();
  end

  initial begin
    for (int a = 0; a < 64; a++) mdl[a] = 16'h0000;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    chk_all("reset");
    for (int a = 0; a < 64; a++) begin
      r = xs();
      wr(a[5:0], r[15:0]);
    end
    for (int n = 0; n <= 4; n++) begin
      r = xs();
      tk(1'b1, 1'b0, nps_pkg::NPS_OP_PACK, 16'(r[5:0] % 60), 16'(r[13:8]),
         16'(n), 1'b1);
    end
    chk_all("pack");
    for (int n = 0; n <= 4; n++) begin
      r = xs();
      tk(1'b1, 1'b0, nps_pkg::NPS_OP_UNPACK, 16'(r[5:0]), 16'(r[13:8] % 60),
         16'(n), 1'b1);
    end
    chk_all("unpack");
    tk(1'b1, 1'b0, nps_pkg::NPS_OP_PACK, 16'h0001, 16'h0002, 16'h0005, 1'b1);
    clr();
    tk(1'b1, 1'b0, nps_pkg::NPS_OP_UNPACK, 16'h0003, 16'h0004, 16'h8000, 1'b1);
    clr();
    tk(1'b1, 1'b0, nps_pkg::NPS_OP_PACK, 16'h003e, 16'h0001, 16'h0003, 1'b1);
    clr();
    tk(1'b1, 1'b0, nps_pkg::NPS_OP_UNPACK, 16'h0001, 16'h003e, 16'h0003, 1'b1);
    clr();
    tk(1'b1, 1'b0, nps_pkg::NPS_OP_SWAP_D, 16'h003f, 16'h0000, 16'h0000, 1'b1);
    clr();
    tk(1'b1, 1'b0, nps_pkg::NPS_OP_SWAP, 16'h0040, 16'h0000, 16'h0000, 1'b1);
    clr();
    // an error in the clear cycle must survive the clear
    @(posedge core_clk);
    err_clr <= 1'b1;
    tk(1'b1, 1'b0, nps_pkg::NPS_OP_SWAP, 16'h0040, 16'h0000, 16'h0000, 1'b1);
    clr();
    chk_all("errors");
    tk(1'b1, 1'b0, nps_pkg::NPS_OP_SWAP, 16'h0007, 16'h0000, 16'h0000, 1'b1);
    tk(1'b1, 1'b0, nps_pkg::NPS_OP_SWAP_D, 16'h003e, 16'h0000, 16'h0000, 1'b1);
    for (int i = 0; i < 3; i++) begin
      tk(1'b1, 1'b0, nps_pkg::NPS_OP_SWAP, 16'h0009, 16'h0000, 16'h0000, 1'b1);
    end
    tk(1'b0, 1'b1, nps_pkg::NPS_OP_SWAP, 16'h0009, 16'h0000, 16'h0000, 1'b0);
    tk(1'b1, 1'b1, nps_pkg::NPS_OP_SWAP_D, 16'h0009, 16'h0000, 16'h0000, 1'b1);
    tk(1'b1, 1'b1, nps_pkg::NPS_OP_SWAP_D, 16'h0009, 16'h0000, 16'h0000, 1'b0);
    chk_all("swap");
    for (int i = 0; i < 24; i++) begin
      r = xs();
      tk(1'b1, 1'b0, nps_pkg::nps_op_e'(r[1:0]), 16'(r[7:2]), 16'(r[13:8]),
         16'(r[18:16] % 6), 1'b1);
    end
    chk_all("random");
    finish_test();
  end
endmodule
`default_nettype wire
